// File: hw/kpars_pkg.sv
package kpars_pkg;
  // ascii codes seen by the parser
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_NAK   = 8'h15;
  localparam logic [7:0] CH_K     = 8'h4B;
  localparam logic [7:0] CH_C     = 8'h43;
  localparam logic [7:0] CH_D     = 8'h44;
  localparam logic [7:0] CH_M     = 8'h4D;
  localparam logic [7:0] CH_S     = 8'h53;
  localparam logic [7:0] CH_DOL   = 8'h24;
  localparam logic [7:0] CH_SLASH = 8'h2F;
  localparam logic [7:0] CH_BANG  = 8'h21;
  localparam logic [7:0] CH_AMP   = 8'h26;
  localparam logic [7:0] CH_DOT   = 8'h2E;
  localparam logic [7:0] CH_LT    = 8'h3C;
  localparam logic [7:0] CH_GT    = 8'h3E;
  localparam logic [7:0] CH_LP    = 8'h28;
  localparam logic [7:0] CH_RP    = 8'h29;
  localparam logic [7:0] CH_PCT   = 8'h25;
  localparam logic [7:0] CH_HASH  = 8'h23;
  localparam logic [7:0] CH_PLUS  = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_F     = 8'h46;
  localparam logic [7:0] CH_0     = 8'h30;
  localparam logic [7:0] CH_9     = 8'h39;

  // key classes reported on the key strobe
  typedef enum logic [3:0] {
    KEY_DIGIT, KEY_LETTER, KEY_NAV, KEY_MENU, KEY_DISP,
    KEY_ACQ, KEY_ACTION, KEY_VIRT, KEY_SYM, KEY_POL, KEY_DIRECT
  } key_class_t;

  // navigation codes
  localparam logic [2:0] NAV_LEFT  = 3'h0;
  localparam logic [2:0] NAV_RIGHT = 3'h1;
  localparam logic [2:0] NAV_UP    = 3'h2;
  localparam logic [2:0] NAV_DOWN  = 3'h3;
  localparam logic [2:0] NAV_NEXT  = 3'h4;
  localparam logic [2:0] NAV_PREV  = 3'h5;

  // setup menu codes
  localparam logic [2:0] MENU_NONE  = 3'h0;
  localparam logic [2:0] MENU_IFACE = 3'h1;
  localparam logic [2:0] MENU_CLOCK = 3'h2;
  localparam logic [2:0] MENU_INPUT = 3'h3;
  localparam logic [2:0] MENU_TRACE = 3'h4;
  localparam logic [2:0] MENU_POL   = 3'h5;
  localparam logic [2:0] MENU_FMT   = 3'h6;

  // direct value limits
  localparam logic [4:0] CLK_MODE_MAX = 5'h05;
  localparam logic [4:0] TRC_CMP_MIN  = 5'h05;
  localparam logic [4:0] TRC_CMP_MAX  = 5'h08;
  localparam logic [4:0] ADDR_MAX     = 5'h1E;

  // action codes
  localparam logic [2:0] ACT_EDIT   = 3'h0;
  localparam logic [2:0] ACT_RECALL = 3'h4;
endpackage

// File: hw/kpars_key_decode.sv
`timescale 1ns/1ps
// decodes one keycode (optionally with a prefix) into class and value
module kpars_key_decode (
  input  wire logic [7:0] i_prefix,
  input  wire logic [7:0] i_char,
  output logic            o_legal,
  output logic            o_is_prefix,
  output logic [3:0]      o_class,
  output logic [7:0]      o_value
);
  // prefix characters start a two-char keycode
  function automatic logic is_pfx(input logic [7:0] c);
    is_pfx = (c == kpars_pkg::CH_DOL) || (c == kpars_pkg::CH_SLASH) ||
             (c == kpars_pkg::CH_BANG) || (c == kpars_pkg::CH_AMP) ||
             (c == kpars_pkg::CH_DOT);
  endfunction

  // combinational table of keycodes
  always_comb
  begin
    o_legal     = 1'b1;
    o_is_prefix = 1'b0;
    o_class     = 4'(kpars_pkg::KEY_SYM);
    o_value     = i_char;
    if (i_prefix == 8'h00)
    begin
      if (is_pfx(i_char))
      begin
        o_is_prefix = 1'b1;
        o_legal     = 1'b0;
      end
      else if (i_char >= kpars_pkg::CH_0 && i_char <= kpars_pkg::CH_9)
      begin
        o_class = 4'(kpars_pkg::KEY_DIGIT);
        o_value = i_char - kpars_pkg::CH_0;
      end
      else if (i_char >= 8'h41 && i_char <= 8'h5A)
        o_class = 4'(kpars_pkg::KEY_LETTER);
      else
      begin
        o_class = 4'(kpars_pkg::KEY_NAV);
        case (i_char)
          kpars_pkg::CH_LT:    o_value = {5'h00, kpars_pkg::NAV_LEFT};
          kpars_pkg::CH_GT:    o_value = {5'h00, kpars_pkg::NAV_RIGHT};
          kpars_pkg::CH_LP:    o_value = {5'h00, kpars_pkg::NAV_UP};
          kpars_pkg::CH_RP:    o_value = {5'h00, kpars_pkg::NAV_DOWN};
          kpars_pkg::CH_PCT:   o_value = {5'h00, kpars_pkg::NAV_NEXT};
          kpars_pkg::CH_HASH:  o_value = {5'h00, kpars_pkg::NAV_PREV};
          kpars_pkg::CH_PLUS:  o_class = 4'(kpars_pkg::KEY_POL);
          kpars_pkg::CH_MINUS: o_class = 4'(kpars_pkg::KEY_POL);
          default:             o_legal = 1'b0;
        endcase
      end
    end
    else
    begin
      case (i_prefix)
        kpars_pkg::CH_DOL:
        begin
          o_class = 4'(kpars_pkg::KEY_MENU);
          case (i_char)
            8'h5A:   o_value = {5'h00, kpars_pkg::MENU_IFACE};
            8'h43:   o_value = {5'h00, kpars_pkg::MENU_CLOCK};
            8'h49:   o_value = {5'h00, kpars_pkg::MENU_INPUT};
            8'h53:   o_value = {5'h00, kpars_pkg::MENU_TRACE};
            8'h50:   o_value = {5'h00, kpars_pkg::MENU_POL};
            8'h47:   o_class = 4'(kpars_pkg::KEY_DISP);
            8'h44:   o_class = 4'(kpars_pkg::KEY_DISP);
            8'h54:   o_class = 4'(kpars_pkg::KEY_DISP);
            8'h3B:   o_class = 4'(kpars_pkg::KEY_SYM);
            default: o_legal = 1'b0;
          endcase
        end
        kpars_pkg::CH_SLASH:
        begin
          o_class = 4'(kpars_pkg::KEY_ACTION);
          if (i_char >= 8'h30 && i_char <= 8'h34)
            o_value = i_char - kpars_pkg::CH_0;
          else if (i_char >= 8'h35 && i_char <= 8'h38)
          begin
            o_class = 4'(kpars_pkg::KEY_VIRT);
            o_value = i_char - kpars_pkg::CH_0;
          end
          else
            o_legal = 1'b0;
        end
        kpars_pkg::CH_BANG:
        begin
          o_value = i_char - kpars_pkg::CH_0;
          case (i_char)
            8'h31, 8'h33, 8'h34, 8'h36, 8'h37: o_class = 4'(kpars_pkg::KEY_DISP);
            8'h30, 8'h32, 8'h35, 8'h38:        o_class = 4'(kpars_pkg::KEY_ACQ);
            default:                           o_legal = 1'b0;
          endcase
        end
        kpars_pkg::CH_AMP:
          o_legal = (i_char == kpars_pkg::CH_DOT) || (i_char == kpars_pkg::CH_LT) ||
                    (i_char == kpars_pkg::CH_GT) || (i_char == 8'h3D);
        kpars_pkg::CH_DOT:
        begin
          o_class = 4'(kpars_pkg::KEY_VIRT);
          o_legal = (i_char == kpars_pkg::CH_0);
        end
        default: o_legal = 1'b0;
      endcase
    end
  end
endmodule

// File: hw/kpars_top.sv
`timescale 1ns/1ps
// Overview of operation
// - one record format set, five types
// - terminator ends every record
// - listener accepts D, C, K, M records
// - talker emits only K, M, S records
// - accept CR or CR LF terminator
// - talker terminator form is selectable
// - K record keycodes act as keys
// - CR, CR LF terminate with or without EOI; EOI alone is ignored
// - grouped keycodes executed in arrival order
// - digits load numeric field at cursor
// - spaces anywhere are dropped
// - wait terminator; early new record id taken as body
// - decode six field navigation keycodes
// - decode setup menu selection keycodes
// - decode display function keycodes
// - decode edit insert delete save recall
// - single digit sets menu field directly
// - clock mode direct codes zero to five
// - trace condition codes zero to eight
// - plus true, minus false polarity
// - bus address direct value up to 30
// - illegal keycode: service request or NAK
module kpars_top (
  input  wire logic       i_sys_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_rx_valid,
  input  wire logic [7:0] i_rx_char,
  input  wire logic       i_rx_eoi,
  input  wire logic       i_rx_serial,
  input  wire logic [2:0] i_field_kind,
  input  wire logic       i_tx_req,
  input  wire logic [7:0] i_tx_id,
  input  wire logic       i_term_lf,
  input  wire logic       i_tx_ready,
  output logic            o_rx_ready,
  output logic            o_key_valid,
  output logic [3:0]      o_key_class,
  output logic [7:0]      o_key_value,
  output logic            o_field_load,
  output logic [7:0]      o_field_value,
  output logic            o_rec_valid,
  output logic [7:0]      o_rec_char,
  output logic [7:0]      o_rec_id,
  output logic            o_rec_end,
  output logic            o_srq,
  output logic            o_tx_valid,
  output logic [7:0]      o_tx_char,
  output logic            o_tx_busy,
  output logic            o_tx_refused
);
  // field kinds reported by the menu logic for direct digits
  localparam logic [2:0] FK_NONE  = 3'h0;
  localparam logic [2:0] FK_NUM   = 3'h1;
  localparam logic [2:0] FK_ENUM  = 3'h2;
  localparam logic [2:0] FK_CLOCK = 3'h3;
  localparam logic [2:0] FK_TRACE = 3'h4;
  localparam logic [2:0] FK_ADDR  = 3'h5;

  typedef enum logic [2:0] {
    S_IDLE, S_KEYS, S_PASS, S_DISCARD, S_GOT_CR
  } rx_state_t;

  typedef enum logic [1:0] {
    T_IDLE, T_ID, T_CR, T_LF
  } tx_state_t;

  rx_state_t  rx_q;
  tx_state_t  tx_q;
  logic [7:0] prefix_q;
  logic [7:0] num_q;
  logic       num_act_q;
  logic [7:0] rec_id_q;
  logic       bad_q;
  logic [7:0] tx_id_q;
  logic       tx_lf_q;

  logic       dec_legal;
  logic       dec_pfx;
  logic [3:0] dec_class;
  logic [7:0] dec_value;
  logic       is_term;
  logic       is_space;
  logic       is_digit;
  logic       take;
  logic       key_ok;
  logic       illegal;
  logic       digit_ok;

  // id letter check for listening
  function automatic logic listen_id(input logic [7:0] c);
    listen_id = (c == kpars_pkg::CH_D) || (c == kpars_pkg::CH_C) ||
                (c == kpars_pkg::CH_K) || (c == kpars_pkg::CH_M);
  endfunction

  // id letter check for talking
  function automatic logic talk_id(input logic [7:0] c);
    talk_id = (c == kpars_pkg::CH_K) || (c == kpars_pkg::CH_M) ||
              (c == kpars_pkg::CH_S);
  endfunction

  // keycode table
  kpars_key_decode u_dec (
    .i_prefix    (prefix_q),
    .i_char      (i_rx_char),
    .o_legal     (dec_legal),
    .o_is_prefix (dec_pfx),
    .o_class     (dec_class),
    .o_value     (dec_value)
  );

  // character classification
  assign take     = i_rx_valid && o_rx_ready;
  // cr ends a record, lf swallowed after it
  assign is_term  = (i_rx_char == kpars_pkg::CH_CR);
  assign is_space = (i_rx_char == kpars_pkg::CH_SP);
  assign is_digit = (i_rx_char >= kpars_pkg::CH_0) && (i_rx_char <= kpars_pkg::CH_9) &&
                    (prefix_q == 8'h00);
  assign o_rx_ready = 1'b1;

  // direct digit range per field kind
  always_comb
  begin
    digit_ok = 1'b1;
    case (i_field_kind)
      // clock mode codes zero to five
      FK_CLOCK: digit_ok = (dec_value[4:0] <= kpars_pkg::CLK_MODE_MAX);
      FK_TRACE: digit_ok = (dec_value[4:0] <= kpars_pkg::TRC_CMP_MAX);
      default:  digit_ok = 1'b1;
    endcase
  end

  assign key_ok  = dec_legal && (!is_digit || digit_ok);
  assign illegal = take && (rx_q == S_KEYS) && !is_term && !is_space && !dec_pfx &&
                   !key_ok && !(is_digit && (i_field_kind == FK_NUM ||
                   i_field_kind == FK_ADDR));

  // receive record state machine
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rx_q <= S_IDLE;
    else if (take)
    begin
      case (rx_q)
        S_IDLE:
        begin
          if (is_term || i_rx_char == kpars_pkg::CH_SP || i_rx_char == kpars_pkg::CH_LF)
            rx_q <= S_IDLE;
          else if (i_rx_char == kpars_pkg::CH_K)
            rx_q <= S_KEYS;
          else if (listen_id(i_rx_char))
            rx_q <= S_PASS;
          else
            rx_q <= S_DISCARD;
        end
        S_KEYS, S_PASS, S_DISCARD:
          if (is_term)
            rx_q <= S_GOT_CR;
        S_GOT_CR:
        begin
          // optional lf, else next record id
          if (i_rx_char == kpars_pkg::CH_LF || is_term || i_rx_char == kpars_pkg::CH_SP)
            rx_q <= S_IDLE;
          else if (i_rx_char == kpars_pkg::CH_K)
            rx_q <= S_KEYS;
          else if (listen_id(i_rx_char))
            rx_q <= S_PASS;
          else
            rx_q <= S_DISCARD;
        end
        default: rx_q <= S_IDLE;
      endcase
    end
  end

  // keycode prefix holder
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      prefix_q <= 8'h00;
    else if (take)
    begin
      if (rx_q == S_KEYS && dec_pfx && !is_term)
        prefix_q <= i_rx_char;
      else if (!is_space || rx_q != S_KEYS)
        prefix_q <= 8'h00;
    end
  end

  // record id and error latch per record
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rec_id_q <= 8'h00;
      bad_q    <= 1'b0;
    end
    else if (take)
    begin
      if ((rx_q == S_IDLE || rx_q == S_GOT_CR) && !is_term &&
          i_rx_char != kpars_pkg::CH_SP && i_rx_char != kpars_pkg::CH_LF)
      begin
        rec_id_q <= i_rx_char;
        bad_q    <= !listen_id(i_rx_char);
      end
      else if (illegal)
        bad_q <= 1'b1;
    end
  end

  // multi digit value for numeric fields
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      num_q     <= 8'h00;
      num_act_q <= 1'b0;
    end
    else if (take && rx_q == S_KEYS && !is_space)
    begin
      if (is_digit && (i_field_kind == FK_NUM || i_field_kind == FK_ADDR))
      begin
        num_q     <= 8'(num_q * 8'd10 + (i_rx_char - kpars_pkg::CH_0));
        num_act_q <= 1'b1;
      end
      else
      begin
        num_q     <= 8'h00;
        num_act_q <= 1'b0;
      end
    end
  end

  // numeric field load when digit run ends
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_field_load  <= 1'b0;
      o_field_value <= 8'h00;
    end
    else
    begin
      o_field_load <= 1'b0;
      if (take && rx_q == S_KEYS && num_act_q && !is_space &&
          !(is_digit && (i_field_kind == FK_NUM || i_field_kind == FK_ADDR)))
      begin
        o_field_load  <= (i_field_kind != FK_ADDR) ||
                         (num_q <= {3'h0, kpars_pkg::ADDR_MAX});
        o_field_value <= num_q;
      end
    end
  end

  // key strobe, one per keycode in arrival order
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_key_valid <= 1'b0;
      o_key_class <= 4'h0;
      o_key_value <= 8'h00;
    end
    else
    begin
      o_key_valid <= 1'b0;
      if (take && rx_q == S_KEYS && !is_term && !is_space && !dec_pfx && key_ok &&
          !(is_digit && (i_field_kind == FK_NUM || i_field_kind == FK_ADDR)))
      begin
        o_key_valid <= 1'b1;
        o_key_value <= dec_value;
        // digit in menu field is direct
        if (is_digit && i_field_kind != FK_NONE)
          o_key_class <= 4'(kpars_pkg::KEY_DIRECT);
        else
          o_key_class <= dec_class;
      end
    end
  end

  // non-keystroke record body passed on
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_rec_valid <= 1'b0;
      o_rec_char  <= 8'h00;
      o_rec_id    <= 8'h00;
      o_rec_end   <= 1'b0;
    end
    else
    begin
      // c, d, m bodies go to record handler
      o_rec_valid <= take && rx_q == S_PASS && !is_term && !is_space;
      o_rec_end   <= take && rx_q == S_PASS && is_term;
      if (take && rx_q == S_PASS)
      begin
        o_rec_char <= i_rx_char;
        o_rec_id   <= rec_id_q;
      end
    end
  end

  // error report per interface at terminator
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_srq <= 1'b0;
    else if (take && is_term && (bad_q || illegal) && rx_q != S_GOT_CR && !i_rx_serial)
      o_srq <= 1'b1;
    else if (take && (rx_q == S_IDLE || rx_q == S_GOT_CR) && i_rx_char > kpars_pkg::CH_SP)
      o_srq <= 1'b0;
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      tx_q    <= T_IDLE;
      tx_id_q <= 8'h00;
      tx_lf_q <= 1'b0;
    end
    else
    begin
      case (tx_q)
        T_IDLE:
          // only k, m, s records and the serial nak leave the device
          if (i_tx_req && talk_id(i_tx_id))
          begin
            tx_q    <= T_ID;
            tx_id_q <= i_tx_id;
            tx_lf_q <= i_term_lf;
          end
          else if (take && is_term && (bad_q || illegal) && rx_q != S_GOT_CR &&
                   i_rx_serial)
          begin
            tx_q    <= T_ID;
            tx_id_q <= kpars_pkg::CH_NAK;
            tx_lf_q <= 1'b0;
          end
        T_ID:
          if (i_tx_ready)
            tx_q <= (tx_id_q == kpars_pkg::CH_NAK) ? T_IDLE : T_CR;
        T_CR:
          if (i_tx_ready)
            tx_q <= tx_lf_q ? T_LF : T_IDLE;
        T_LF:
          if (i_tx_ready)
            tx_q <= T_IDLE;
        default: tx_q <= T_IDLE;
      endcase
    end
  end

  // transmit byte outputs
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_tx_refused <= 1'b0;
    else
      o_tx_refused <= i_tx_req && tx_q == T_IDLE && !talk_id(i_tx_id);
  end

  assign o_tx_valid = (tx_q != T_IDLE);
  assign o_tx_busy  = (tx_q != T_IDLE);
  always_comb
  begin
    case (tx_q)
      T_ID:    o_tx_char = tx_id_q;
      T_CR:    o_tx_char = kpars_pkg::CH_CR;
      T_LF:    o_tx_char = kpars_pkg::CH_LF;
      default: o_tx_char = 8'h00;
    endcase
  end
endmodule

// File: sim/kpars_checker.sv
`timescale 1ns/1ps
// port timing checks for the record parser
module kpars_checker (
  input wire logic       i_sys_clk,
  input wire logic       i_arst_n,
  input wire logic       i_rx_valid,
  input wire logic [7:0] i_rx_char,
  input wire logic       i_rx_serial,
  input wire logic       i_tx_req,
  input wire logic [7:0] i_tx_id,
  input wire logic       i_tx_ready,
  input wire logic       o_rx_ready,
  input wire logic       o_key_valid,
  input wire logic       o_rec_valid,
  input wire logic       o_rec_end,
  input wire logic       o_srq,
  input wire logic       o_tx_valid,
  input wire logic [7:0] o_tx_char,
  input wire logic       o_tx_busy,
  input wire logic       o_tx_refused
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_arst_n);
  logic rv_q;
  logic cr_q;
  logic ser_q;
  logic id_ok;
  logic tx_is_id;
  // talker id letters
  assign id_ok = i_tx_id inside {kpars_pkg::CH_K, kpars_pkg::CH_M, kpars_pkg::CH_S};
  assign tx_is_id = o_tx_char inside {kpars_pkg::CH_K, kpars_pkg::CH_M, kpars_pkg::CH_S};
  // last char strobe, kept as cause of outputs
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rv_q  <= 1'b0;
      cr_q  <= 1'b0;
      ser_q <= 1'b0;
    end
    else
    begin
      rv_q  <= i_rx_valid;
      cr_q  <= i_rx_valid && i_rx_char == kpars_pkg::CH_CR;
      ser_q <= i_rx_serial;
    end
  end
  a_rx_never_stall : assert property (o_rx_ready)
    else $error("receiver stalled");
  a_tx_good_start : assert property (!o_tx_busy && i_tx_req && id_ok |=> o_tx_valid
    && o_tx_char == $past(i_tx_id)) else $error("talker id not offered");
  a_tx_bad_refused : assert property (!o_tx_busy && i_tx_req && !id_ok |=>
    o_tx_refused && !o_tx_valid) else $error("bad id not refused");
  a_tx_byte_held : assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid
    && $stable(o_tx_char)) else $error("byte dropped while stalled");
  a_tx_cr_follows : assert property (o_tx_valid && i_tx_ready && tx_is_id |=>
    o_tx_valid && o_tx_char == kpars_pkg::CH_CR) else $error("no CR after id");
  a_nak_alone : assert property (o_tx_valid && i_tx_ready
    && o_tx_char == kpars_pkg::CH_NAK |=> !o_tx_valid) else $error("NAK not single");
  a_busy_tracks : assert property (o_tx_busy == o_tx_valid)
    else $error("busy differs from valid");
  a_space_dropped : assert property (i_rx_valid && i_rx_char == kpars_pkg::CH_SP
    |=> !o_key_valid && !o_rec_valid && !o_rec_end) else $error("space had effect");
  a_key_has_cause : assert property (o_key_valid |-> rv_q)
    else $error("key without char");
  a_end_on_cr : assert property (o_rec_end |-> cr_q)
    else $error("record end without CR");
  a_srq_parallel : assert property ($rose(o_srq) |-> cr_q && !ser_q)
    else $error("service request out of place");
  c_lf_sent : cover property (o_tx_valid && i_tx_ready && o_tx_char == kpars_pkg::CH_LF);
  c_nak_sent : cover property (o_tx_valid && o_tx_char == kpars_pkg::CH_NAK);
  c_srq_rise : cover property ($rose(o_srq));
  c_refused : cover property (o_tx_refused);
endmodule

bind kpars_top kpars_checker i_kpars_checker (
  .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_rx_valid(i_rx_valid),
  .i_rx_char(i_rx_char), .i_rx_serial(i_rx_serial), .i_tx_req(i_tx_req),
  .i_tx_id(i_tx_id), .i_tx_ready(i_tx_ready), .o_rx_ready(o_rx_ready),
  .o_key_valid(o_key_valid), .o_rec_valid(o_rec_valid), .o_rec_end(o_rec_end),
  .o_srq(o_srq), .o_tx_valid(o_tx_valid), .o_tx_char(o_tx_char),
  .o_tx_busy(o_tx_busy), .o_tx_refused(o_tx_refused)
);

// File: sim/kpars_sink.sv
`timescale 1ns/1ps
// remote controller side: takes talker bytes, may stall
module kpars_sink (
  input  wire logic       i_sys_clk,
  input  wire logic       i_slow,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_char,
  output logic            o_tx_ready
);
  logic [7:0] got[$];
  logic       ph_q = 1'b0;
  initial o_tx_ready = 1'b0;
  // keeps every byte taken while ready, terminators included
  always @(posedge i_sys_clk)
  begin
    ph_q <= ~ph_q;
    o_tx_ready <= ~i_slow | ph_q;
    if (i_tx_valid && o_tx_ready)
      got.push_back(i_tx_char);
  end
endmodule

// File: sim/kpars_top_test.sv
`timescale 1ns/1ps
module kpars_top_test;
  logic        i_sys_clk = 1'b0;
  logic        i_arst_n = 1'b0;
  logic        i_rx_valid = 1'b0;
  logic [7:0]  i_rx_char = 8'h00;
  logic        i_rx_eoi = 1'b0;
  logic        i_rx_serial = 1'b0;
  logic [2:0]  i_field_kind = 3'h0;
  logic        i_tx_req = 1'b0;
  logic [7:0]  i_tx_id = 8'h00;
  logic        i_term_lf = 1'b0;
  logic        slow = 1'b0;
  logic        i_tx_ready, o_rx_ready, o_key_valid, o_field_load, o_rec_valid;
  logic        o_rec_end, o_srq, o_tx_valid, o_tx_busy, o_tx_refused;
  logic [3:0]  o_key_class;
  logic [7:0]  o_key_value, o_field_value, o_rec_char, o_rec_id, o_tx_char;
  logic [3:0]  kc[$];
  logic [7:0]  kv[$];
  logic [7:0]  fv[$];
  logic [15:0] rq[$];
  int          err_count = 0;
  int          cmp_count = 0;
  int          ref_n = 0;

  kpars_top i_kpars_top (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_rx_valid(i_rx_valid),
    .i_rx_char(i_rx_char), .i_rx_eoi(i_rx_eoi), .i_rx_serial(i_rx_serial),
    .i_field_kind(i_field_kind), .i_tx_req(i_tx_req), .i_tx_id(i_tx_id),
    .i_term_lf(i_term_lf), .i_tx_ready(i_tx_ready), .o_rx_ready(o_rx_ready),
    .o_key_valid(o_key_valid), .o_key_class(o_key_class), .o_key_value(o_key_value),
    .o_field_load(o_field_load), .o_field_value(o_field_value),
    .o_rec_valid(o_rec_valid), .o_rec_char(o_rec_char), .o_rec_id(o_rec_id),
    .o_rec_end(o_rec_end), .o_srq(o_srq), .o_tx_valid(o_tx_valid),
    .o_tx_char(o_tx_char), .o_tx_busy(o_tx_busy), .o_tx_refused(o_tx_refused)
  );
  kpars_sink i_kpars_sink (
    .i_sys_clk(i_sys_clk), .i_slow(slow), .i_tx_valid(o_tx_valid),
    .i_tx_char(o_tx_char), .o_tx_ready(i_tx_ready)
  );

  // clock
  initial
  begin
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  // collect decoded events
  always @(posedge i_sys_clk)
  begin
    if (o_key_valid)
    begin
      kc.push_back(o_key_class);
      kv.push_back(o_key_value);
    end
    if (o_field_load) fv.push_back(o_field_value);
    if (o_rec_valid) rq.push_back({o_rec_id, o_rec_char});
    if (o_rec_end) rq.push_back({o_rec_id, 8'h0D});
    if (o_tx_refused) ref_n++;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic clr();
    kc.delete();
    kv.delete();
    fv.delete();
    rq.delete();
    i_kpars_sink.got.delete();
    ref_n = 0;
  endtask

  // one char per cycle, back to back
  task automatic send(input string s, input bit eoi);
    foreach (s[k])
    begin
      @(posedge i_sys_clk);
      i_rx_valid <= 1'b1;
      i_rx_char <= s[k];
      i_rx_eoi <= eoi && s[k] == 8'h0D;
    end
    @(posedge i_sys_clk);
    i_rx_valid <= 1'b0;
    i_rx_eoi <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
  endtask

  task automatic keys(input string nm, input logic [3:0] cls, input logic [7:0] v0,
                      input int n, input bit val);
    chk(nm, 16'(kc.size()), 16'(n));
    foreach (kc[k])
    begin
      chk(nm, {12'h000, kc[k]}, {12'h000, cls});
      if (val) chk(nm, {8'h00, kv[k]}, {8'h00, v0 + 8'(k)});
    end
  endtask

  task automatic t_keys();
    clr();
    send("K$Z$ C$I$S$P\r", 1'b0);
    keys("menu", kpars_pkg::KEY_MENU, 8'h01, 5, 1'b1);
    clr();
    send("K<>()%#\r\n", 1'b1);
    keys("nav", kpars_pkg::KEY_NAV, 8'h00, 6, 1'b1);
    chk("srq", {15'h0000, o_srq}, 16'h0000);
    clr();
    send("K/0/1/2/3/4\r", 1'b0);
    keys("act", kpars_pkg::KEY_ACTION, 8'h00, 5, 1'b1);
    clr();
    send("K$G$D$T\r", 1'b0);
    keys("disp", kpars_pkg::KEY_DISP, 8'h00, 3, 1'b0);
    clr();
    send("K+-\r", 1'b0);
    keys("pol", kpars_pkg::KEY_POL, 8'h00, 2, 1'b0);
  endtask

  // each digit from lo to hi, then one past the top
  task automatic t_direct(input logic [2:0] kind, input int lo, input int hi);
    string s;
    s = "K0\r";
    i_field_kind <= kind;
    for (int d = lo; d <= hi + 1; d++)
    begin
      clr();
      s[1] = byte'(8'h30 + d);
      send(s, 1'b0);
      chk("srq", {15'h0000, o_srq}, 16'(d > hi));
      if (d <= hi) keys("dir", kpars_pkg::KEY_DIRECT, 8'(d), 1, 1'b1);
    end
  endtask

  task automatic t_fields();
    clr();
    i_field_kind <= 3'h1;
    send("K1 00<\r", 1'b0);
    chk("num", {8'h00, fv[0]}, 16'h0064);
    chk("num_n", 16'(fv.size()), 16'h0001);
    clr();
    i_field_kind <= 3'h5;
    send("K30\r", 1'b0);
    send("K31\r", 1'b0);
    chk("addr", {8'h00, fv[0]}, 16'h001E);
    chk("addr_n", 16'(fv.size()), 16'h0001);
    i_field_kind <= 3'h0;
  endtask

  task automatic t_records();
    logic [15:0] e[7] = '{16'h4350, 16'h4353, 16'h430D, 16'h4437, 16'h440D,
                          16'h4D32, 16'h4D0D};
    clr();
    send("CP S\r", 1'b0);
    send("D7\r", 1'b0);
    send("M2\r", 1'b0);
    chk("rec_n", 16'(rq.size()), 16'h0007);
    foreach (rq[k]) chk("rec", rq[k], e[k]);
    send("Q1\r\n", 1'b0);
    chk("srq", {15'h0000, o_srq}, 16'h0001);
    send("K<\r", 1'b0);
    chk("srq", {15'h0000, o_srq}, 16'h0000);
    clr();
    send("K$C", 1'b0);
    send("K<\r", 1'b0);
    chk("open_n", 16'(kc.size()), 16'h0003);
    chk("open_k", {8'h00, kv[1]}, {8'h00, kpars_pkg::CH_K});
    clr();
    i_rx_serial <= 1'b1;
    send("Q\r", 1'b0);
    chk("nak_n", 16'(i_kpars_sink.got.size()), 16'h0001);
    chk("nak", {8'h00, i_kpars_sink.got[0]}, 16'h0015);
    i_rx_serial <= 1'b0;
  endtask

  task automatic tx(input logic [7:0] id, input logic lf);
    @(posedge i_sys_clk);
    i_tx_req <= 1'b1;
    i_tx_id <= id;
    i_term_lf <= lf;
    @(posedge i_sys_clk);
    i_tx_req <= 1'b0;
    for (int k = 0; k < 40 && (k < 3 || o_tx_busy); k++) @(negedge i_sys_clk);
  endtask

  task automatic t_talk();
    logic [7:0] e[5] = '{8'h4B, 8'h0D, 8'h0A, 8'h4D, 8'h0D};
    clr();
    slow <= 1'b1;
    tx(kpars_pkg::CH_K, 1'b1);
    tx(kpars_pkg::CH_M, 1'b0);
    tx(kpars_pkg::CH_D, 1'b1);
    chk("tx_n", 16'(i_kpars_sink.got.size()), 16'h0005);
    foreach (e[k]) chk("tx", {8'h00, i_kpars_sink.got[k]}, {8'h00, e[k]});
    chk("refuse", 16'(ref_n), 16'h0001);
  endtask

  // watchdog
  initial
  begin
    repeat (20000) @(posedge i_sys_clk);
    err_count++;
    report_and_stop();
  end

  initial
  begin
    repeat (16) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    t_keys();
    t_direct(3'h3, 0, 5);
    t_direct(3'h4, 5, 8);
    t_fields();
    t_records();
    t_talk();
    report_and_stop();
  end
endmodule
